// ### logic/bidir_fifo_pkg.sv
// constants, encodings and helper functions for the bidirectional fifo
// assumes a single core clock; port clocks arrive as sampled pins
package bidir_fifo_pkg;
    localparam int DATA_W = 36;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int PAR_BIT = 8;
    localparam int QUEUE_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam int SYNC_PIN_W = 15 + 2 * DATA_W;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 7'h40;
    localparam logic [CNT_W-1:0] ALMOST_EMPTY_LEVEL = 7'h08;
    localparam logic [CNT_W-1:0] ALMOST_FULL_LEVEL = 7'h38;
    localparam logic [1:0] LAST_WORD_POS = 2'h1;
    localparam logic [1:0] LAST_BYTE_POS = 2'h3;
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] MASK_OFS = 12'h008;
    localparam logic [11:0] LEVEL_OFS = 12'h00c;
    localparam int CTRL_BIG_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_W = 4;
    localparam int STAT_MAILBOX_1 = 0;
    localparam int STAT_MAILBOX_2 = 1;
    localparam int STAT_Q1_FULL = 2;
    localparam int STAT_Q2_FULL = 3;
    // {size_sel_hi, size_sel_lo}
    typedef enum logic [1:0] {
        SIZE_LONG = 2'h0, SIZE_BYTE = 2'h1, SIZE_WORD = 2'h2, SIZE_MAIL = 2'h3
    } port_size_t;
    // {swap_sel_hi, swap_sel_lo}
    typedef enum logic [1:0] {
        SWAP_LL = 2'h0, SWAP_LH = 2'h1, SWAP_HL = 2'h2, SWAP_HH = 2'h3
    } swap_mode_t;

    // every swap is its own inverse, so writes reuse it
    function automatic logic [DATA_W-1:0] swap_long(input logic [DATA_W-1:0] w, input swap_mode_t m);
        logic [BYTE_W-1:0] a, b, c, d;
        {a, b, c, d} = w;
        case (m)
            SWAP_LH: swap_long = {d, c, b, a};
            SWAP_HL: swap_long = {c, d, a, b};
            SWAP_HH: swap_long = {b, a, d, c};
            default: swap_long = {a, b, c, d};
        endcase
    endfunction : swap_long

    // odd parity regenerated on each 9-bit byte
    function automatic logic [DATA_W-1:0] gen_parity(input logic [DATA_W-1:0] w);
        gen_parity = w;
        for (int i = 0; i < DATA_W / BYTE_W; i++) begin
            gen_parity[i*BYTE_W+PAR_BIT] = ~^w[i*BYTE_W +: PAR_BIT];
        end
    endfunction : gen_parity

    function automatic logic last_access(input port_size_t s, input logic [1:0] pos);
        last_access = (s == SIZE_LONG) || (s == SIZE_WORD && pos == LAST_WORD_POS) ||
            (s == SIZE_BYTE && pos == LAST_BYTE_POS);
    endfunction : last_access

    // lane slot of access pos: big-endian walks from the top byte
    function automatic logic [1:0] lane_index(input logic [1:0] pos, input logic big);
        lane_index = big ? ~pos : pos;
    endfunction : lane_index
endpackage : bidir_fifo_pkg

// ### logic/bidir_fifo_portb_swap_flags.sv
// bidirectional fifo: two 36-bit queues, port-b bus sizing, swapping, flags
// assumes port clocks are slow pins sampled by core_clk_in; apb host on core clock
// Summary of operation
// - byte reads: LL and LH lane orders
// - byte reads: HL and HH lane orders
// - port-b flags rise on next port-b edge
// - port-a flags rise on next port-a edge
// - empty_flag_b falls only at final narrow read
// - queue-2 count moves at final narrow write
// - queue-1 count moves at final narrow read
// - full_flag_b falls only at final narrow write
// - almost_empty_b falls only at final narrow read
// - almost_full_b falls only at final narrow write
// - both size selects low mean long word
// - parity generation off passes stored parity
// - port-b write, sizes high, fills mailbox_2
// - port-b read, sizes high, drives mailbox_1
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_portb_swap_flags (
    // core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // port a pins
    input wire logic port_a_clock_in,
    input wire logic chip_sel_a_n_in,
    input wire logic write_not_read_a_in,
    input wire logic mailbox_sel_a_in,
    input wire logic enable_a_in,
    input wire logic parity_gen_a_in,
    input wire logic [35:0] data_a_in,
    output logic [35:0] data_a_out,
    output logic data_a_oe_out,
    output logic empty_flag_a_n_out,
    output logic full_flag_a_n_out,
    output logic almost_empty_a_n_out,
    output logic almost_full_a_n_out,
    output logic mail_flag_2_n_out,
    // port b pins
    input wire logic port_b_clock_in,
    input wire logic chip_sel_b_n_in,
    input wire logic write_not_read_b_in,
    input wire logic port_b_access_enable_in,
    input wire logic size_sel_hi_in,
    input wire logic size_sel_lo_in,
    input wire logic swap_sel_hi_in,
    input wire logic swap_sel_lo_in,
    input wire logic parity_gen_b_in,
    input wire logic [35:0] data_b_in,
    output logic [35:0] data_b_out,
    output logic data_b_oe_out,
    output logic empty_flag_b_n_out,
    output logic full_flag_b_n_out,
    output logic almost_empty_b_n_out,
    output logic almost_full_b_n_out,
    output logic mail_flag_1_n_out,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out
);
    localparam int DW = bidir_fifo_pkg::DATA_W;
    localparam int PW = bidir_fifo_pkg::PTR_W;
    localparam int CW = bidir_fifo_pkg::CNT_W;
    localparam int BW = bidir_fifo_pkg::BYTE_W;
    localparam int WW = bidir_fifo_pkg::WORD_W;

    logic [bidir_fifo_pkg::SYNC_PIN_W-1:0] pin_meta_reg, pin_sync_reg;
    logic [1:0] clk_prev_reg;
    logic a_clk, b_clk, csa_n, wra, mailbox_sel_a, ena, csb_n, wrb, port_b_access_enable, sz_hi, sz_lo, sw_hi, sw_lo, parity_gen_a, parity_gen_b;
    logic [DW-1:0] da, db;
    logic a_edge, b_edge, a_sel, b_sel, big, b_mail;
    logic a_wr_q1, a_wr_mail, a_rd_q2, a_rd_mail, b_rd_q1, b_wr_q2, b_rd_mail, b_wr_mail;
    logic b_rd_last, b_wr_last;
    bidir_fifo_pkg::port_size_t size;
    bidir_fifo_pkg::swap_mode_t swap;
    logic [DW-1:0] q1_mem [bidir_fifo_pkg::QUEUE_DEPTH];
    logic [DW-1:0] q2_mem [bidir_fifo_pkg::QUEUE_DEPTH];
    logic [CW-1:0] q1_wptr_reg, q1_rptr_reg, q2_wptr_reg, q2_rptr_reg;
    logic [CW-1:0] q1_wptr_next, q1_rptr_next, q2_wptr_next, q2_rptr_next, q1_cnt_next, q2_cnt_next;
    logic [1:0] b_rd_pos_reg, b_wr_pos_reg, b_rd_idx, b_wr_idx;
    logic [DW-1:0] q1_head, q2_head, rd_word, b_lane, q2_asm_reg, wr_asm;
    logic [DW-1:0] mailbox_1_reg, mailbox_2_reg;
    logic [31:0] ctrl_reg;
    logic [bidir_fifo_pkg::STAT_W-1:0] status_reg, mask_reg, status_ev, status_clr;
    logic apb_setup, apb_write;

    // two-stage synchroniser on every port pin, port clocks included; apb pins and reset are not synchronised
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            clk_prev_reg <= 2'h0;
        end else begin
            pin_meta_reg <= {port_a_clock_in, port_b_clock_in, chip_sel_a_n_in, write_not_read_a_in,
                mailbox_sel_a_in, enable_a_in, chip_sel_b_n_in, write_not_read_b_in,
                port_b_access_enable_in, size_sel_hi_in, size_sel_lo_in, swap_sel_hi_in,
                swap_sel_lo_in, parity_gen_a_in, parity_gen_b_in, data_a_in, data_b_in};
            pin_sync_reg <= pin_meta_reg;
            clk_prev_reg <= {a_clk, b_clk};
        end
    end
    assign {a_clk, b_clk, csa_n, wra, mailbox_sel_a, ena, csb_n, wrb, port_b_access_enable, sz_hi, sz_lo, sw_hi, sw_lo, parity_gen_a, parity_gen_b,
        da, db} = pin_sync_reg;

    // port clock edges become one-cycle enables; data sampled alongside
    assign a_edge = a_clk & ~clk_prev_reg[1];
    assign b_edge = b_clk & ~clk_prev_reg[0];
    assign size = bidir_fifo_pkg::port_size_t'({sz_hi, sz_lo});
    assign swap = bidir_fifo_pkg::swap_mode_t'({sw_hi, sw_lo});
    assign big = ctrl_reg[bidir_fifo_pkg::CTRL_BIG_BIT];
    assign b_mail = (size == bidir_fifo_pkg::SIZE_MAIL);

    // access decode; transfers into a full or from an empty queue are dropped
    assign a_sel = a_edge & ~csa_n & ena;
    assign b_sel = b_edge & ~csb_n & port_b_access_enable;
    assign a_wr_q1 = a_sel & wra & ~mailbox_sel_a & full_flag_a_n_out;
    assign a_wr_mail = a_sel & wra & mailbox_sel_a;
    assign a_rd_q2 = a_sel & ~wra & ~mailbox_sel_a & empty_flag_a_n_out;
    assign a_rd_mail = a_sel & ~wra & mailbox_sel_a;
    assign b_rd_q1 = b_sel & ~wrb & ~b_mail & empty_flag_b_n_out;
    assign b_wr_q2 = b_sel & wrb & ~b_mail & full_flag_b_n_out;
    assign b_rd_mail = b_sel & ~wrb & b_mail;
    assign b_wr_mail = b_sel & wrb & b_mail;
    assign b_rd_last = bidir_fifo_pkg::last_access(size, b_rd_pos_reg);
    assign b_wr_last = bidir_fifo_pkg::last_access(size, b_wr_pos_reg);

    // pointers move once per long word; flags see the post-edge count
    assign q1_wptr_next = q1_wptr_reg + CW'(a_wr_q1);
    assign q1_rptr_next = q1_rptr_reg + CW'(b_rd_q1 & b_rd_last);
    assign q2_wptr_next = q2_wptr_reg + CW'(b_wr_q2 & b_wr_last);
    assign q2_rptr_next = q2_rptr_reg + CW'(a_rd_q2);
    assign q1_cnt_next = q1_wptr_next - q1_rptr_next;
    assign q2_cnt_next = q2_wptr_next - q2_rptr_next;
    assign q1_head = q1_mem[q1_rptr_reg[PW-1:0]];
    assign q2_head = q2_mem[q2_rptr_reg[PW-1:0]];
    assign rd_word = bidir_fifo_pkg::swap_long(q1_head, swap);
    assign b_rd_idx = bidir_fifo_pkg::lane_index(b_rd_pos_reg, big);
    assign b_wr_idx = bidir_fifo_pkg::lane_index(b_wr_pos_reg, big);

    // read lane: narrow data copied on every lane so either endian sees it
    always_comb begin
        case (size)
            bidir_fifo_pkg::SIZE_WORD: b_lane = {2{rd_word[int'(b_rd_idx[0])*WW +: WW]}};
            bidir_fifo_pkg::SIZE_BYTE: b_lane = {4{rd_word[int'(b_rd_idx)*BW +: BW]}};
            bidir_fifo_pkg::SIZE_MAIL: b_lane = mailbox_1_reg;
            default: b_lane = rd_word;
        endcase
    end

    // write assembly: narrow pieces land in their slot of the swapped word
    always_comb begin
        wr_asm = q2_asm_reg;
        case (size)
            bidir_fifo_pkg::SIZE_WORD: wr_asm[int'(b_wr_idx[0])*WW +: WW] = big ? db[DW-1 -: WW] : db[WW-1:0];
            bidir_fifo_pkg::SIZE_BYTE: wr_asm[int'(b_wr_idx)*BW +: BW] = big ? db[DW-1 -: BW] : db[BW-1:0];
            default: wr_asm = db;
        endcase
    end

    // queue storage and pointers
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q1_wptr_reg <= '0;
            q1_rptr_reg <= '0;
            q2_wptr_reg <= '0;
            q2_rptr_reg <= '0;
        end else begin
            q1_wptr_reg <= q1_wptr_next;
            q1_rptr_reg <= q1_rptr_next;
            q2_wptr_reg <= q2_wptr_next;
            q2_rptr_reg <= q2_rptr_next;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (a_wr_q1) begin
            q1_mem[q1_wptr_reg[PW-1:0]] <= da;
        end
        if (b_wr_q2 && b_wr_last) begin
            q2_mem[q2_wptr_reg[PW-1:0]] <= bidir_fifo_pkg::swap_long(wr_asm, swap);
        end
    end

    // position counters; a size change mid-word is not resynchronised
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            b_rd_pos_reg <= 2'h0;
            b_wr_pos_reg <= 2'h0;
            q2_asm_reg <= '0;
        end else begin
            if (b_rd_q1) begin
                b_rd_pos_reg <= b_rd_last ? 2'h0 : b_rd_pos_reg + 2'h1;
            end
            if (b_wr_q2) begin
                b_wr_pos_reg <= b_wr_last ? 2'h0 : b_wr_pos_reg + 2'h1;
                q2_asm_reg <= wr_asm;
            end
        end
    end

    // mailboxes; flag low means new mail waiting
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mailbox_1_reg <= '0;
            mailbox_2_reg <= '0;
            mail_flag_1_n_out <= 1'b1;
            mail_flag_2_n_out <= 1'b1;
        end else begin
            if (a_wr_mail) begin
                mailbox_1_reg <= da;
            end
            if (b_wr_mail) begin
                mailbox_2_reg <= db;
            end
            mail_flag_1_n_out <= a_wr_mail ? 1'b0 : (b_rd_mail ? 1'b1 : mail_flag_1_n_out);
            mail_flag_2_n_out <= b_wr_mail ? 1'b0 : (a_rd_mail ? 1'b1 : mail_flag_2_n_out);
        end
    end

    // port a data and flags, all moved on port-a edges only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_a_out <= '0;
            data_a_oe_out <= 1'b0;
            empty_flag_a_n_out <= 1'b0;
            almost_empty_a_n_out <= 1'b0;
            full_flag_a_n_out <= 1'b1;
            almost_full_a_n_out <= 1'b1;
        end else if (a_edge) begin
            data_a_oe_out <= ~csa_n & ~wra;
            if (a_rd_q2 || a_rd_mail) begin
                data_a_out <= parity_gen_a ? bidir_fifo_pkg::gen_parity(a_rd_mail ? mailbox_2_reg : q2_head)
                    : (a_rd_mail ? mailbox_2_reg : q2_head);
            end
            empty_flag_a_n_out <= (q2_cnt_next != '0);
            almost_empty_a_n_out <= (q2_cnt_next > bidir_fifo_pkg::ALMOST_EMPTY_LEVEL);
            full_flag_a_n_out <= (q1_cnt_next != bidir_fifo_pkg::DEPTH_CNT);
            almost_full_a_n_out <= (q1_cnt_next < bidir_fifo_pkg::ALMOST_FULL_LEVEL);
        end
    end

    // port b data and flags; counts only change at the final narrow access
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_b_out <= '0;
            data_b_oe_out <= 1'b0;
            empty_flag_b_n_out <= 1'b0;
            almost_empty_b_n_out <= 1'b0;
            full_flag_b_n_out <= 1'b1;
            almost_full_b_n_out <= 1'b1;
        end else if (b_edge) begin
            data_b_oe_out <= ~csb_n & ~wrb;
            if (b_rd_q1 || b_rd_mail) begin
                data_b_out <= parity_gen_b ? bidir_fifo_pkg::gen_parity(b_lane) : b_lane;
            end
            empty_flag_b_n_out <= (q1_cnt_next != '0);
            almost_empty_b_n_out <= (q1_cnt_next > bidir_fifo_pkg::ALMOST_EMPTY_LEVEL);
            full_flag_b_n_out <= (q2_cnt_next != bidir_fifo_pkg::DEPTH_CNT);
            almost_full_b_n_out <= (q2_cnt_next < bidir_fifo_pkg::ALMOST_FULL_LEVEL);
        end
    end

    // apb slave: pready raised in the access phase, so one wait-free access
    assign apb_setup = psel_in & ~penable_in;
    assign apb_write = psel_in & penable_in & pready_out & pwrite_in;
    assign status_clr = (apb_write && paddr_in == bidir_fifo_pkg::STATUS_OFS) ?
        pwdata_in[bidir_fifo_pkg::STAT_W-1:0] : '0;
    always_comb begin
        status_ev = '0;
        status_ev[bidir_fifo_pkg::STAT_MAILBOX_1] = a_wr_mail;
        status_ev[bidir_fifo_pkg::STAT_MAILBOX_2] = b_wr_mail;
        status_ev[bidir_fifo_pkg::STAT_Q1_FULL] = a_wr_q1 && q1_cnt_next == bidir_fifo_pkg::DEPTH_CNT;
        status_ev[bidir_fifo_pkg::STAT_Q2_FULL] = b_wr_q2 && b_wr_last && q2_cnt_next == bidir_fifo_pkg::DEPTH_CNT;
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= bidir_fifo_pkg::CTRL_RESET;
            mask_reg <= '0;
            status_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            if (apb_write && paddr_in == bidir_fifo_pkg::CTRL_OFS) begin
                ctrl_reg <= 32'(pwdata_in[bidir_fifo_pkg::CTRL_BIG_BIT]);
            end
            if (apb_write && paddr_in == bidir_fifo_pkg::MASK_OFS) begin
                mask_reg <= pwdata_in[bidir_fifo_pkg::STAT_W-1:0];
            end
            status_reg <= (status_reg & ~status_clr) | status_ev; // set wins over clear
            irq_out <= |(status_reg & mask_reg);
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= apb_setup;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
            if (apb_setup) begin
                case (paddr_in)
                    bidir_fifo_pkg::CTRL_OFS: prdata_out <= ctrl_reg;
                    bidir_fifo_pkg::STATUS_OFS: prdata_out <= 32'(status_reg);
                    bidir_fifo_pkg::MASK_OFS: prdata_out <= 32'(mask_reg);
                    bidir_fifo_pkg::LEVEL_OFS: prdata_out <= 32'({q2_wptr_reg - q2_rptr_reg, 1'b0,
                        q1_wptr_reg - q1_rptr_reg});
                    default: pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_EMPTY_B_RISE: assert property (b_edge && q1_cnt_next != '0 |=> empty_flag_b_n_out)
        else $error("empty_flag_b not released");
    AST_FULL_A_RISE: assert property (a_edge && q1_cnt_next != bidir_fifo_pkg::DEPTH_CNT |=> full_flag_a_n_out)
        else $error("full_flag_a not released");
    AST_BYTE_LH_BIG: assert property (b_rd_q1 && size == bidir_fifo_pkg::SIZE_BYTE && swap == bidir_fifo_pkg::SWAP_LH
        && big && !parity_gen_b && b_rd_pos_reg == 2'h0 |=> data_b_out[DW-1 -: BW] == $past(q1_head[BW-1:0]))
        else $error("byte LH big-endian order wrong");
    AST_BYTE_HL_LITTLE: assert property (b_rd_q1 && size == bidir_fifo_pkg::SIZE_BYTE && swap == bidir_fifo_pkg::SWAP_HL
        && !big && !parity_gen_b && b_rd_pos_reg == 2'h0 |=> data_b_out[BW-1:0] == $past(q1_head[DW-BW-1 -: BW]))
        else $error("byte HL little-endian order wrong");
    AST_NARROW_READ_HOLD: assert property (b_rd_q1 && !b_rd_last |=> $stable(q1_rptr_reg))
        else $error("queue-1 popped on partial read");
    AST_POP_ONCE: assert property (b_rd_q1 && b_rd_last |=> q1_rptr_reg == $past(q1_rptr_reg) + 7'h01)
        else $error("queue-1 pop missing");
    AST_NARROW_WRITE_HOLD: assert property (b_wr_q2 && !b_wr_last |=> $stable(q2_wptr_reg))
        else $error("queue-2 pushed on partial write");
    AST_LONG_SIZE: assert property (b_sel && !sz_hi && !sz_lo |-> b_rd_last && b_wr_last)
        else $error("long-word size not decoded");
    AST_PARITY_OFF_A: assert property (a_rd_q2 && !parity_gen_a |=> data_a_out == $past(q2_head))
        else $error("port-a parity altered while off");
    AST_MAILBOX_2_WRITE: assert property (b_wr_mail |=> mailbox_2_reg == $past(db) && $stable(q2_wptr_reg))
        else $error("mailbox_2 write failed");
    AST_MAILBOX_1_READ: assert property (b_rd_mail && !parity_gen_b |=> data_b_out == $past(mailbox_1_reg) ##1 mail_flag_1_n_out)
        else $error("mailbox_1 read failed");
    COV_BYTE_WORD: cover property (b_rd_q1 && size == bidir_fifo_pkg::SIZE_BYTE && b_rd_last);
    COV_WORD_WRITE: cover property (b_wr_q2 && size == bidir_fifo_pkg::SIZE_WORD && b_wr_last);
    COV_Q1_FULL: cover property (a_wr_q1 && q1_cnt_next == bidir_fifo_pkg::DEPTH_CNT);
    COV_IRQ: cover property (!irq_out ##1 irq_out);
endmodule : bidir_fifo_portb_swap_flags
`default_nettype wire

// ### dv/port_clock_src.sv
// free-running port clock of the bus master on one fifo port
// assumes nothing of the core clock; its phase is unrelated to it
`timescale 1ns/1ps
`default_nettype none
module port_clock_src #(
    parameter realtime HALF = 41.0
) (
    // port clock
    output logic clk_out
);
    // odd half period keeps port edges off the core clock grid
    initial begin
        clk_out = 1'b0;
        forever #(HALF) clk_out = ~clk_out;
    end
endmodule : port_clock_src
`default_nettype wire

// ### dv/bidir_fifo_portb_swap_flags_bench.sv
// bench: queue and mailbox traffic on both ports, byte swaps, flags, apb, irq
// assumes free-running port clocks; pins held across each port clock rise
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_portb_swap_flags_bench;
    logic clk, rst_n, pa_clk, pb_clk, cs_a_n, wr_a, mb_a, pg_a, cs_b_n, wr_b, en_b, pg_b;
    logic psel, pen, pwr, rdy, err, irq, mf1, mf2, aerr, oe_a, oe_b;
    logic [1:0] size, swap;
    logic [35:0] d_a, d_b, q_a, q_b, w;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, ard;
    logic [3:0] flg_a, flg_b; // empty, full, almost empty, almost full
    logic [35:0] q1[$];
    int n_fail, total_checks, seed, cyc;
    bidir_fifo_portb_swap_flags dut_u (
        .core_clk_in(clk), .rst_n_in(rst_n), .port_a_clock_in(pa_clk), .chip_sel_a_n_in(cs_a_n),
        .write_not_read_a_in(wr_a), .mailbox_sel_a_in(mb_a), .enable_a_in(1'b1), .parity_gen_a_in(pg_a),
        .data_a_in(d_a), .data_a_out(q_a), .data_a_oe_out(oe_a), .empty_flag_a_n_out(flg_a[3]),
        .full_flag_a_n_out(flg_a[2]), .almost_empty_a_n_out(flg_a[1]), .almost_full_a_n_out(flg_a[0]),
        .mail_flag_2_n_out(mf2), .port_b_clock_in(pb_clk), .chip_sel_b_n_in(cs_b_n),
        .write_not_read_b_in(wr_b), .port_b_access_enable_in(en_b), .size_sel_hi_in(size[1]),
        .size_sel_lo_in(size[0]), .swap_sel_hi_in(swap[1]), .swap_sel_lo_in(swap[0]),
        .parity_gen_b_in(pg_b), .data_b_in(d_b), .data_b_out(q_b), .data_b_oe_out(oe_b),
        .empty_flag_b_n_out(flg_b[3]), .full_flag_b_n_out(flg_b[2]), .almost_empty_b_n_out(flg_b[1]),
        .almost_full_b_n_out(flg_b[0]), .mail_flag_1_n_out(mf1), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(err), .irq_out(irq)
    );
    port_clock_src #(.HALF(41.0)) pa_u (.clk_out(pa_clk));
    port_clock_src #(.HALF(37.0)) pb_u (.clk_out(pb_clk));
    // core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard; the whole run needs well under a tenth of this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // byte at slot s (0 = top) of a word after swap mode m
    function automatic logic [8:0] sbyte(input logic [35:0] v, input logic [1:0] m, input int s);
        int i;
        i = s ^ ((4 - int'(m)) & 3);
        return v[35 - 9 * i -: 9];
    endfunction : sbyte
    function automatic logic [35:0] sw(input logic [35:0] v, input logic [1:0] m);
        return {sbyte(v, m, 0), sbyte(v, m, 1), sbyte(v, m, 2), sbyte(v, m, 3)};
    endfunction : sw
    // pins change while the port clock is low, stay past the synchroniser
    task automatic a_op(input logic wr, input logic mb, input logic [35:0] d);
        @(negedge pa_clk);
        @(posedge clk);
        cs_a_n <= 1'b0;
        wr_a <= wr;
        mb_a <= mb;
        d_a <= d;
        @(posedge pa_clk);
        repeat (5) @(posedge clk);
        cs_a_n <= 1'b1;
        @(posedge clk);
    endtask : a_op
    task automatic b_op(input logic wr, input logic [1:0] sz, input logic [35:0] d);
        @(negedge pb_clk);
        @(posedge clk);
        cs_b_n <= 1'b0;
        wr_b <= wr;
        size <= sz;
        d_b <= d;
        @(posedge pb_clk);
        repeat (5) @(posedge clk);
        cs_b_n <= 1'b1;
        @(posedge clk);
    endtask : b_op
    // flag of one port settles only after that port's own next edge
    task automatic edge_wait(input logic b);
        if (b)
            @(posedge pb_clk);
        else
            @(posedge pa_clk);
        repeat (5) @(posedge clk);
    endtask : edge_wait
    // apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (rdy !== 1'b1); // a missing answer is caught by the hang guard
        ard = prd;
        aerr = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    initial begin
        seed = 24592;
        {wr_a, mb_a, pg_a, wr_b, pg_b, psel, pen, pwr, rst_n} = '0;
        {cs_a_n, cs_b_n, en_b} = 3'h7;
        {size, swap, paddr, pwd, d_a, d_b} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("flags_b", flg_b, 4'h5);
        check("flags_a", flg_a, 4'h5);
        // byte reads of queue_1, every swap mode at both endian settings
        for (int e = 1; e >= 0; e--) begin
            apb(1'b1, 12'h000, {31'h0, e[0]});
            for (int m = 0; m < 4; m++) begin
                w = {$random(seed), $random(seed)};
                swap <= m[1:0];
                q1.push_back(w);
                a_op(1'b1, 1'b0, w);
                edge_wait(1'b1);
                check("empty_b", flg_b[3], 1'b1);
                for (int k = 0; k < 4; k++) begin
                    b_op(1'b0, 2'h1, 36'h0);
                    check("byte", e ? q_b[35:27] : q_b[8:0], sbyte(q1[0], m[1:0], e ? k : 3 - k));
                    if (k == 3)
                        void'(q1.pop_front());
                    check("empty_b", flg_b[3], q1.size() != 0);
                    check("aempty_b", flg_b[1], 1'b0);
                    check("full_b", flg_b[2], 1'b1);
                    check("afull_b", flg_b[0], 1'b1);
                    check("oe_b", oe_b, 1'b1);
                end
            end
        end
        // queue_2: long writes in every swap mode, then a word write pair
        for (int m = 0; m < 5; m++) begin
            w = {$random(seed), $random(seed)};
            swap <= m[1:0];
            if (m < 4) begin
                b_op(1'b1, 2'h0, w);
            end else begin
                b_op(1'b1, 2'h2, {2{w[17:0]}});
                edge_wait(1'b0);
                check("empty_a", flg_a[3], 1'b0);
                b_op(1'b1, 2'h2, {2{w[35:18]}});
            end
            edge_wait(1'b0);
            check("empty_a", flg_a[3], 1'b1);
            a_op(1'b0, 1'b0, 36'h0);
            check("read_a", q_a, sw(w, m[1:0]));
            check("oe_a", oe_a, 1'b1);
            check("full_a", flg_a[2], 1'b1);
        end
        // mailboxes, interrupt raised, masked and cleared, unmapped access
        w = {$random(seed), $random(seed)};
        a_op(1'b1, 1'b1, w);
        check("mail_flag_1", mf1, 1'b0);
        check("irq", irq, 1'b0);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'b1);
        b_op(1'b0, 2'h3, 36'h0);
        check("mail_1", q_b, w);
        check("mail_flag_1", mf1, 1'b1);
        b_op(1'b1, 2'h3, ~w);
        check("mail_flag_2", mf2, 1'b0);
        a_op(1'b0, 1'b1, 36'h0);
        check("mail_2", q_a, ~w);
        check("mail_flag_2", mf2, 1'b1);
        apb(1'b1, 12'h004, 32'h3);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {aerr, ard}, 36'h1_0000_0000);
        apb(1'b0, 12'h00c, 32'h0);
        check("level", ard, 36'h0);
        complete_run();
    end
endmodule : bidir_fifo_portb_swap_flags_bench
`default_nettype wire
